/* rtl/crcc_pkg.sv */
// constants, encodings and the configuration check for the reset sequencer
// assumes a single client clock; crcc_top imports the whole package, the bench calls crcc_pkg::crcc_cfg_legal by scope
package crcc_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_FREQ_KHZ          = 250000;
	localparam int unsigned HOT_RESET_HOLD_NS     = 1000;
	localparam int unsigned HOT_RESET_HOLD_CYCLES =
		(HOT_RESET_HOLD_NS * CLK_FREQ_KHZ + 999999) / 1000000;
	localparam int unsigned RESET_SYNC_STAGES     = 3;
	localparam int unsigned LOCK_SYNC_STAGES      = 2;

	// ----------------------------------------------------------------
	// link generation and client clock encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] LINK_GEN1  = 2'h1;
	localparam logic [1:0] LINK_GEN2  = 2'h2;
	localparam logic [1:0] LINK_GEN3  = 2'h3;
	localparam logic [1:0] CLK_62P5   = 2'h0;
	localparam logic [1:0] CLK_125    = 2'h1;
	localparam logic [1:0] CLK_250    = 2'h2;
	localparam int unsigned WIDTH_64  = 64;
	localparam int unsigned WIDTH_128 = 128;
	localparam int unsigned WIDTH_256 = 256;

	// ----------------------------------------------------------------
	// default build options
	// ----------------------------------------------------------------
	localparam int unsigned DEF_NUM_PF     = 2;
	localparam int unsigned DEF_NUM_VF     = 6;
	localparam int unsigned DEF_NUM_XCVR   = 8;
	localparam int unsigned DEF_LANES      = 8;
	localparam logic [1:0]  DEF_GEN        = LINK_GEN3;
	localparam int unsigned DEF_IF_WIDTH   = WIDTH_256;
	localparam logic [1:0]  DEF_CLK_SEL    = CLK_250;
	localparam bit          DEF_PF0_FLR_EN = 1'b1;
	localparam bit          DEF_MSG_IND_EN = 1'b1;

	typedef enum logic [1:0] {
		PH_HARD_RESET,
		PH_TRAIN,
		PH_ACTIVE,
		PH_HOT_RESET
	} crcc_phase_type;

	// ----------------------------------------------------------------
	// legal width / clock pairs per generation and lane count
	// ----------------------------------------------------------------
	function automatic bit crcc_cfg_legal(
		input logic [1:0]  gen,
		input int unsigned lanes,
		input int unsigned width,
		input logic [1:0]  clk_sel
	);
		bit w64;
		bit w128;
		bit w256;
		w64  = (width == WIDTH_64);
		w128 = (width == WIDTH_128);
		w256 = (width == WIDTH_256);
		crcc_cfg_legal = 1'b0;
		case (gen)
			LINK_GEN1: begin // (R18)
				if (lanes == 1 || lanes == 2)
					crcc_cfg_legal = w64 && clk_sel != 2'h3;
				else if (lanes == 4)
					crcc_cfg_legal = w64 && (clk_sel == CLK_125 ||
						clk_sel == CLK_250);
				else if (lanes == 8)
					crcc_cfg_legal = (w64 && clk_sel == CLK_250) ||
						(w128 && clk_sel == CLK_125);
			end
			LINK_GEN2: begin // (R19)
				if (lanes == 1)
					crcc_cfg_legal = w64 && clk_sel != 2'h3;
				else if (lanes == 2)
					crcc_cfg_legal = w64 && (clk_sel == CLK_125 ||
						clk_sel == CLK_250);
				else if (lanes == 4)
					crcc_cfg_legal = (w64 && clk_sel == CLK_250) ||
						(w128 && clk_sel == CLK_125);
				else if (lanes == 8)
					crcc_cfg_legal = (w128 && clk_sel == CLK_250) ||
						(w256 && clk_sel == CLK_125);
			end
			LINK_GEN3: begin // (R20)
				if (lanes == 1)
					crcc_cfg_legal = w64 && (clk_sel == CLK_125 ||
						clk_sel == CLK_250);
				else if (lanes == 2)
					crcc_cfg_legal = (w64 && clk_sel == CLK_250) ||
						(w128 && clk_sel == CLK_125);
				else if (lanes == 4)
					crcc_cfg_legal = (w128 && clk_sel == CLK_250) ||
						(w256 && clk_sel == CLK_125);
				else if (lanes == 8)
					crcc_cfg_legal = w256 && clk_sel == CLK_250;
			end
			default: crcc_cfg_legal = 1'b0;
		endcase
	endfunction : crcc_cfg_legal

endpackage : crcc_pkg

/* rtl/crcc_sync.sv */
// multi-stage level synchroniser with asynchronous clear to zero
// assumes d may change at any time relative to clk
`timescale 1ns/1ps
module crcc_sync #(
	parameter int unsigned WIDTH  = 1,
	parameter int unsigned STAGES = 2
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [STAGES-1:0][WIDTH-1:0] chain_q;

	// only the next stage reads the first stage
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chain_q <= '0;
		end else begin
			chain_q <= {chain_q[STAGES-2:0], d};
		end
	end

	assign q = chain_q[STAGES-1];
endmodule : crcc_sync

/* rtl/crcc_top.sv */
// reset sequencing and client interface configuration for the endpoint
// assumes clk is the client clock; lock inputs arrive from other domains,
// link and client event inputs are already on clk
//
// Notes on behaviour
// (R1) fundamental reset: asynchronous, active low, resets all
// (R2) after release, train link and resume unaided
// (R3) system connects sideband reset, or makes one locally
// (R4) cold and warm resets both use resetn
// (R5) in-band hot reset resets endpoint, flags indication
// (R6) function reset sets its in-progress bit
// (R7) client sets done bit after function reset
// (R8) first function reset support set by parameter
// (R9) client reset deasserts synchronously to client clock
// (R10) client reset asserted during fundamental reset
// (R11) client reset asserted on wrapper PLL unlock
// (R12) client reset asserted on any transceiver unlock
// (R13) client reset held until all causes clear
// (R14) four streaming client ports
// (R15) requests accepted while completions return
// (R16) one width of 64, 128 or 256 bits
// (R17) client clock 62.5, 125 or 250 MHz
// (R18) gen1 legal width and clock pairs
// (R19) gen2 legal width and clock pairs
// (R20) gen3 legal width and clock pairs
// (R21) optional message indication instead of forwarding
// (R22) reset release passes a multi-stage synchroniser
`timescale 1ns/1ps
module crcc_top
	import crcc_pkg::*;
#(
	parameter int unsigned NUM_PF      = DEF_NUM_PF,
	parameter int unsigned NUM_VF      = DEF_NUM_VF,
	parameter int unsigned NUM_XCVR    = DEF_NUM_XCVR,
	parameter int unsigned LANES       = DEF_LANES,
	parameter logic [1:0]  LINK_GEN    = DEF_GEN,
	parameter int unsigned IF_WIDTH    = DEF_IF_WIDTH,
	parameter logic [1:0]  CLK_SEL     = DEF_CLK_SEL,
	parameter bit          PF0_FLR_EN  = DEF_PF0_FLR_EN,
	parameter bit          MSG_IND_EN  = DEF_MSG_IND_EN,
	parameter int unsigned HOLD_CYCLES = HOT_RESET_HOLD_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              wrapper_pll_locked,
	input  wire logic [NUM_XCVR-1:0] xcvr_pll_locked,
	input  wire logic              link_up,
	input  wire logic              link_hot_reset_rx,
	input  wire logic              link_msg_rx,
	input  wire logic [NUM_PF-1:0] pf_func_reset_req,
	input  wire logic [NUM_VF-1:0] vf_func_reset_req,
	input  wire logic [NUM_PF-1:0] pf_func_reset_complete,
	input  wire logic [NUM_VF-1:0] vf_func_reset_complete,
	output logic                   xcvr_hard_reset,
	output logic                   link_train_en,
	output logic                   hot_reset_ind,
	output logic      [NUM_PF-1:0] pf_func_reset_active,
	output logic      [NUM_VF-1:0] vf_func_reset_active,
	output logic                   pf0_func_reset_capable,
	output logic                   client_reset,
	output logic                   cfg_legal,
	output logic                   incoming_request_port_en,
	output logic                   outgoing_completion_port_en,
	output logic                   outgoing_request_port_en,
	output logic                   incoming_completion_port_en,
	output logic                   msg_ind,
	output logic                   msg_forward
);

	// ----------------------------------------------------------------
	// build-time configuration
	// ----------------------------------------------------------------
	// a single width serves all four streaming ports by construction
	localparam bit CFG_OK =
		crcc_cfg_legal(LINK_GEN, LANES, IF_WIDTH, CLK_SEL); // (R16)
	localparam int unsigned HOLD_W = $clog2(HOLD_CYCLES + 1);
	localparam logic [NUM_PF-1:0] PF_FLR_MASK =
		{{(NUM_PF-1){1'b1}}, PF0_FLR_EN}; // (R8)

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		crcc_phase_type    phase;
		logic [HOLD_W-1:0] hold_cnt;
		logic              xcvr_hard_reset;
		logic              client_reset;
		logic              link_train_en;
		logic              hot_reset_ind;
		logic [NUM_PF-1:0] pf_active;
		logic [NUM_VF-1:0] vf_active;
		logic              ports_en;
		logic              msg_ind;
		logic              msg_forward;
		logic              cfg_legal;
		logic              pf0_capable;
	} crcc_state_type;

	localparam crcc_state_type S_RESET = '{
		phase:           PH_HARD_RESET,
		hold_cnt:        '0,
		xcvr_hard_reset: 1'b1,
		client_reset:    1'b1,
		link_train_en:   1'b0,
		hot_reset_ind:   1'b0,
		pf_active:       '0,
		vf_active:       '0,
		ports_en:        1'b0,
		msg_ind:         1'b0,
		msg_forward:     1'b0,
		cfg_legal:       1'b0,
		pf0_capable:     1'b0
	};

	crcc_state_type s_q;
	crcc_state_type s_d;

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	logic                rst_released;
	logic [NUM_XCVR:0]   locks_sync;
	logic                causes_clear;

	// release only: assertion of resetn acts at once on every flop
	crcc_sync #(
		.WIDTH  (1),
		.STAGES (RESET_SYNC_STAGES)
	) u_reset_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      (1'b1),
		.q      (rst_released)
	); // (R22)

	crcc_sync #(
		.WIDTH  (NUM_XCVR + 1),
		.STAGES (LOCK_SYNC_STAGES)
	) u_lock_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      ({wrapper_pll_locked, xcvr_pll_locked}),
		.q      (locks_sync)
	);

	// an illegal build never leaves reset; the link cannot run anyway
	assign causes_clear = rst_released && (&locks_sync) && CFG_OK; // (R13)

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [NUM_PF-1:0] pf_set;
		logic [NUM_VF-1:0] vf_set;
		logic              live;
		pf_set = '0;
		vf_set = '0;
		live   = 1'b0;
		s_d    = s_q;
		s_d.msg_ind     = 1'b0;
		s_d.msg_forward = 1'b0;
		s_d.cfg_legal   = CFG_OK; // (R17)
		s_d.pf0_capable = PF0_FLR_EN; // (R8)
		// transceivers stay in hard reset only until the synchronised release of resetn
		s_d.xcvr_hard_reset = !rst_released; // (R1)

		live   = (s_q.phase == PH_TRAIN) || (s_q.phase == PH_ACTIVE);
		pf_set = live ? (pf_func_reset_req & PF_FLR_MASK) : '0;
		vf_set = live ? vf_func_reset_req : '0;

		// a new request in the cycle of its done keeps the bit set
		s_d.pf_active = (s_q.pf_active & ~pf_func_reset_complete)
			| pf_set; // (R6)
		s_d.vf_active = (s_q.vf_active & ~vf_func_reset_complete)
			| vf_set; // (R6)

		case (s_q.phase)
			PH_HARD_RESET: begin
				s_d.client_reset  = 1'b1;
				s_d.link_train_en = 1'b0;
				s_d.ports_en      = 1'b0;
				s_d.hot_reset_ind = 1'b0;
				if (causes_clear) begin
					s_d.phase         = PH_TRAIN; // (R2)
					s_d.client_reset  = 1'b0; // (R9)
					s_d.link_train_en = 1'b1;
				end
			end
			PH_TRAIN: begin
				s_d.link_train_en = 1'b1;
				if (link_up) begin
					s_d.phase    = PH_ACTIVE;
					s_d.ports_en = 1'b1; // (R14)
				end
			end
			PH_ACTIVE: begin
				if (!link_up) begin
					s_d.phase    = PH_TRAIN;
					s_d.ports_en = 1'b0;
				end
			end
			PH_HOT_RESET: begin
				if (s_q.hold_cnt == '0) begin
					s_d.phase         = PH_TRAIN; // (R2)
					s_d.hot_reset_ind = 1'b0;
					s_d.client_reset  = 1'b0;
					s_d.link_train_en = 1'b1;
				end else begin
					s_d.hold_cnt = s_q.hold_cnt - 1'b1;
				end
			end
			default: begin
				s_d.phase = PH_HARD_RESET;
			end
		endcase

		// hot reset clears the whole endpoint, resetn untouched
		if (live && link_hot_reset_rx) begin
			s_d.phase         = PH_HOT_RESET; // (R5)
			s_d.hot_reset_ind = 1'b1; // (R5)
			s_d.client_reset  = 1'b1;
			s_d.link_train_en = 1'b0;
			s_d.ports_en      = 1'b0;
			s_d.hold_cnt      = HOLD_W'(HOLD_CYCLES - 1);
		end

		// the endpoint reset wipes every function reset in flight
		if (s_d.phase == PH_HOT_RESET || s_d.phase == PH_HARD_RESET) begin
			s_d.pf_active = '0;
			s_d.vf_active = '0;
		end

		// received messages: a short flag or a forward on requests
		if (s_q.phase == PH_ACTIVE && link_msg_rx) begin
			if (MSG_IND_EN) begin
				s_d.msg_ind = 1'b1; // (R21)
			end else begin
				s_d.msg_forward = 1'b1;
			end
		end

		// any lost cause wins over every other transition
		if (!causes_clear) begin
			s_d.phase         = PH_HARD_RESET; // (R10) (R11) (R12)
			s_d.client_reset  = 1'b1; // (R13)
			s_d.link_train_en = 1'b0;
			s_d.ports_en      = 1'b0;
			s_d.hot_reset_ind = 1'b0;
			s_d.hold_cnt      = '0;
			s_d.pf_active     = '0;
			s_d.vf_active     = '0;
			s_d.msg_ind       = 1'b0;
			s_d.msg_forward   = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// asynchronous entry, synchronous exit of every reset output
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= S_RESET; // (R1) (R10)
		end else begin
			s_q <= s_d; // (R9)
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign xcvr_hard_reset        = s_q.xcvr_hard_reset;
	assign link_train_en          = s_q.link_train_en;
	assign hot_reset_ind          = s_q.hot_reset_ind;
	assign pf_func_reset_active   = s_q.pf_active;
	assign vf_func_reset_active   = s_q.vf_active;
	assign pf0_func_reset_capable = s_q.pf0_capable;
	assign client_reset           = s_q.client_reset;
	assign cfg_legal              = s_q.cfg_legal;
	assign msg_ind                = s_q.msg_ind;
	assign msg_forward            = s_q.msg_forward;

	// request intake never waits on the completion path, so
	// non-posted requests may be answered as split transactions
	assign incoming_request_port_en    = s_q.ports_en; // (R15)
	assign outgoing_completion_port_en = s_q.ports_en; // (R14)
	assign outgoing_request_port_en    = s_q.ports_en;
	assign incoming_completion_port_en = s_q.ports_en;

endmodule : crcc_top

/* tb/crcc_checker.sv */
// port checker for the reset sequencer
// assumes the bench drives inputs just after the rising clock edge
`timescale 1ns/1ps
module crcc_checker #(
	parameter int unsigned NUM_VF      = 6,
	parameter int unsigned NUM_XCVR    = 8,
	parameter int unsigned HOLD_CYCLES = 2
) (
	input wire logic                clk,
	input wire logic                resetn,
	input wire logic                wrapper_pll_locked,
	input wire logic [NUM_XCVR-1:0] xcvr_pll_locked,
	input wire logic                link_up,
	input wire logic                link_hot_reset_rx,
	input wire logic                link_msg_rx,
	input wire logic [NUM_VF-1:0]   vf_func_reset_req,
	input wire logic [NUM_VF-1:0]   vf_func_reset_complete,
	input wire logic                xcvr_hard_reset,
	input wire logic                link_train_en,
	input wire logic                hot_reset_ind,
	input wire logic [NUM_VF-1:0]   vf_func_reset_active,
	input wire logic                client_reset,
	input wire logic                incoming_request_port_en,
	input wire logic                msg_ind
);
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	logic [15:0]       hot_cnt_q;
	wire  [NUM_VF-1:0] done_live = vf_func_reset_complete &
		~vf_func_reset_req;

	// counts hold cycles; a count is only judged when the hold ends
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			hot_cnt_q <= 16'h0000;
		else
			hot_cnt_q <= hot_reset_ind ? hot_cnt_q + 16'h0001 : 16'h0000;
	end

	sequence s_hot_take;
		$rose(link_hot_reset_rx) && link_train_en;
	endsequence
	sequence s_hot_state;
		hot_reset_ind && client_reset && !link_train_en &&
			vf_func_reset_active == '0;
	endsequence

	a_release_held: assert property ($rose(resetn) |->
		(client_reset && xcvr_hard_reset)[*3]) else $error("early release");
	a_train_after: assert property ($fell(client_reset) |->
		link_train_en && !xcvr_hard_reset) else $error("no training");
	a_wrap_loss: assert property ($fell(wrapper_pll_locked) |->
		##3 client_reset) else $error("pll loss missed");
	a_xcvr_loss: assert property ($fell(&xcvr_pll_locked) |->
		##3 client_reset) else $error("lane loss missed");
	a_hot_enter: assert property (s_hot_take |=> s_hot_state)
		else $error("hot reset not entered");
	// a lock loss cuts the hold short but keeps client reset up
	a_hot_hold: assert property ($fell(hot_reset_ind) &&
		!client_reset |-> hot_cnt_q == 16'(HOLD_CYCLES))
		else $error("hot hold length");
	a_func_set: assert property ((|vf_func_reset_req) &&
		link_train_en && !link_hot_reset_rx |=> (vf_func_reset_active &
		$past(vf_func_reset_req)) == $past(vf_func_reset_req))
		else $error("function reset not flagged");
	a_func_clear: assert property (|(done_live &
		vf_func_reset_active) |=> (vf_func_reset_active &
		$past(done_live)) == '0) else $error("done ignored");
	a_ports_cause: assert property (incoming_request_port_en |->
		!client_reset && link_train_en && !hot_reset_ind)
		else $error("ports open in reset");
	a_msg_pulse: assert property (link_msg_rx &&
		incoming_request_port_en |=> msg_ind) else $error("message lost");
endmodule : crcc_checker

bind crcc_top crcc_checker #(
	.NUM_VF(NUM_VF), .NUM_XCVR(NUM_XCVR), .HOLD_CYCLES(HOLD_CYCLES)
) i_crcc_checker (
	.clk, .resetn, .wrapper_pll_locked, .xcvr_pll_locked, .link_up,
	.link_hot_reset_rx, .link_msg_rx, .vf_func_reset_req,
	.vf_func_reset_complete, .xcvr_hard_reset, .link_train_en,
	.hot_reset_ind, .vf_func_reset_active, .client_reset,
	.incoming_request_port_en, .msg_ind
);

/* tb/crcc_client_model.sv */
// client logic model: answers function resets after a delay
// assumes answer_delay 8'hFF means the client never answers
`timescale 1ns/1ps
module crcc_client_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [7:0] answer_delay,
	input  wire logic [1:0] pf_func_reset_active,
	input  wire logic [5:0] vf_func_reset_active,
	output logic      [1:0] pf_func_reset_complete,
	output logic      [5:0] vf_func_reset_complete
);
	// ------------------------------------------------------------
	// answer
	// ------------------------------------------------------------
	logic [7:0] wait_q;
	wire        busy = answer_delay != 8'hFF &&
		(|{pf_func_reset_active, vf_func_reset_active});

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wait_q                 <= 8'h00;
			pf_func_reset_complete <= 2'h0;
			vf_func_reset_complete <= 6'h00;
		end else begin
			pf_func_reset_complete <= 2'h0;
			vf_func_reset_complete <= 6'h00;
			wait_q                 <= 8'h00;
			if (busy && wait_q < answer_delay)
				wait_q <= wait_q + 8'h01;
			else if (busy) begin
				// one-cycle done pulses, so a stuck done cannot hide a bug
				pf_func_reset_complete <= pf_func_reset_active;
				vf_func_reset_complete <= vf_func_reset_active;
			end
		end
	end
endmodule : crcc_client_model

/* tb/test_core_reset_and_client_config.sv */
// bench for the reset sequencer with a client model
// assumes the default legal build and a short hot reset hold
`timescale 1ns/1ps
module test_core_reset_and_client_config;
	// ------------------------------------------------------------
	// set-up
	// ------------------------------------------------------------
	localparam int unsigned HOLD = 2;
	logic clk, resetn, wrapper_pll_locked, link_up, client_reset;
	logic link_hot_reset_rx, link_msg_rx, msg_ind, msg_forward;
	logic [7:0] xcvr_pll_locked, answer_delay;
	logic [1:0] pf_func_reset_req, pf_func_reset_complete;
	logic [1:0] pf_func_reset_active;
	logic [5:0] vf_func_reset_req, vf_func_reset_complete;
	logic [5:0] vf_func_reset_active;
	logic xcvr_hard_reset, link_train_en, hot_reset_ind, cfg_legal;
	logic pf0_func_reset_capable, incoming_request_port_en;
	logic outgoing_completion_port_en, outgoing_request_port_en;
	logic incoming_completion_port_en;
	int fail_count = 0;
	int checks_done = 0;
	logic [15:0] n;
	wire [3:0] ports = {incoming_request_port_en,
		outgoing_completion_port_en, outgoing_request_port_en,
		incoming_completion_port_en};

	crcc_top #(.HOLD_CYCLES(HOLD)) i_crcc_top (
		.clk, .resetn, .wrapper_pll_locked, .xcvr_pll_locked, .link_up,
		.link_hot_reset_rx, .link_msg_rx, .pf_func_reset_req,
		.vf_func_reset_req, .pf_func_reset_complete,
		.vf_func_reset_complete, .xcvr_hard_reset, .link_train_en,
		.hot_reset_ind, .pf_func_reset_active, .vf_func_reset_active,
		.pf0_func_reset_capable, .client_reset, .cfg_legal,
		.incoming_request_port_en, .outgoing_completion_port_en,
		.outgoing_request_port_en, .incoming_completion_port_en,
		.msg_ind, .msg_forward
	);
	crcc_client_model i_crcc_client_model (
		.clk, .resetn, .answer_delay, .pf_func_reset_active,
		.vf_func_reset_active, .pf_func_reset_complete,
		.vf_func_reset_complete
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic step;
		@(posedge clk);
		#1;
	endtask : step

	task automatic check(input string what, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	task automatic cfg_pair(input logic [1:0] gen, input int unsigned lanes,
		input int unsigned width, input logic [1:0] sel, input logic exp);
		check("cfg pair", 16'(crcc_pkg::crcc_cfg_legal(gen, lanes, width,
			sel)), {15'h0000, exp});
	endtask : cfg_pair

	task automatic wait_rst(input logic v);
		n = 16'h0000;
		while (client_reset !== v) begin
			step();
			n++;
			if (n > 16'h0040) begin
				fail_count++;
				$display("BAD client_reset expected %b seen %b", v, ~v);
				print_verdict();
			end
		end
	endtask : wait_rst

	task automatic s_reset;
		@(posedge clk);
		resetn <= 1'b0;
		repeat (5) @(posedge clk);
		#1;
		check("hard", {client_reset, xcvr_hard_reset, link_train_en},
			16'h0006);
		@(posedge clk);
		resetn <= 1'b1;
		wait_rst(1'b0);
		check("release", n, 16'h0004);
		check("train", {link_train_en, xcvr_hard_reset}, 16'h0002);
		check("cfg", {cfg_legal, pf0_func_reset_capable}, 16'h0003);
	endtask : s_reset

	task automatic s_train;
		check("idle", ports, 16'h0000);
		@(posedge clk);
		link_up <= 1'b1;
		step();
		check("ports", ports, 16'h000F);
		@(posedge clk);
		link_up <= 1'b0;
		step();
		check("down", {ports, client_reset}, 16'h0000);
		@(posedge clk);
		link_up <= 1'b1;
		step();
		check("up", ports, 16'h000F);
	endtask : s_train

	task automatic s_msg;
		@(posedge clk);
		link_msg_rx <= 1'b1;
		step();
		check("msg", {msg_ind, msg_forward}, 16'h0002);
		@(posedge clk);
		link_msg_rx <= 1'b0;
		#1;
		check("msg2", {msg_ind, msg_forward}, 16'h0002);
		step();
		check("msg end", {msg_ind, ports}, 16'h000F);
	endtask : s_msg

	task automatic s_func;
		@(posedge clk);
		pf_func_reset_req <= 2'h1;
		vf_func_reset_req <= 6'h08;
		@(posedge clk);
		pf_func_reset_req <= 2'h0;
		vf_func_reset_req <= 6'h00;
		#1;
		check("set", {pf_func_reset_active, vf_func_reset_active},
			16'h0048);
		n = 16'h0000;
		while (vf_func_reset_active !== 6'h00 && n < 16'h0020) begin
			step();
			n++;
		end
		check("clear", {pf_func_reset_active, vf_func_reset_active},
			16'h0000);
		check("waited", 16'(n > 16'h0003), 16'h0001);
		if (n == 16'h0020)
			print_verdict();
		@(posedge clk);
		answer_delay      <= 8'hFF;
		vf_func_reset_req <= 6'h20;
		@(posedge clk);
		vf_func_reset_req <= 6'h00;
		repeat (8) step();
		check("sticky", vf_func_reset_active, 16'h0020);
	endtask : s_func

	task automatic s_hot;
		@(posedge clk);
		link_hot_reset_rx <= 1'b1;
		@(posedge clk);
		link_hot_reset_rx <= 1'b0;
		#1;
		check("hot", {hot_reset_ind, client_reset, link_train_en,
			xcvr_hard_reset, ports, vf_func_reset_active},
			16'h3000);
		n = 16'h0000;
		while (hot_reset_ind === 1'b1 && n < 16'h0100) begin
			step();
			n++;
		end
		check("hold", n, 16'(HOLD));
		check("resume", {client_reset, link_train_en}, 16'h0001);
	endtask : s_hot

	task automatic s_lock;
		@(posedge clk);
		wrapper_pll_locked <= 1'b0;
		wait_rst(1'b1);
		check("pll", n, 16'h0003);
		@(posedge clk);
		xcvr_pll_locked    <= 8'hFE;
		wrapper_pll_locked <= 1'b1;
		repeat (6) step();
		check("one left", client_reset, 16'h0001);
		@(posedge clk);
		xcvr_pll_locked <= 8'hFF;
		wait_rst(1'b0);
		check("all clear", n, 16'h0003);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			xcvr_pll_locked <= ~(8'h01 << i);
			wait_rst(1'b1);
			check("lane", n, 16'h0003);
			@(posedge clk);
			xcvr_pll_locked <= 8'hFF;
			wait_rst(1'b0);
		end
	endtask : s_lock

	// gen codes 1 to 3; clock codes 0=62.5, 1=125, 2=250, 3 unused
	task automatic s_cfg;
		cfg_pair(2'h1, 1, 64, 2'h0, 1'b1);
		cfg_pair(2'h1, 4, 64, 2'h0, 1'b0);
		cfg_pair(2'h1, 8, 128, 2'h1, 1'b1);
		cfg_pair(2'h2, 2, 64, 2'h0, 1'b0);
		cfg_pair(2'h2, 8, 256, 2'h1, 1'b1);
		cfg_pair(2'h2, 4, 128, 2'h2, 1'b0);
		cfg_pair(2'h3, 1, 64, 2'h0, 1'b0);
		cfg_pair(2'h3, 2, 128, 2'h1, 1'b1);
		cfg_pair(2'h3, 8, 128, 2'h2, 1'b0);
		cfg_pair(2'h3, 8, 256, 2'h3, 1'b0);
	endtask : s_cfg

	initial begin
		resetn             = 1'b0;
		wrapper_pll_locked = 1'b1;
		xcvr_pll_locked    = 8'hFF;
		link_up            = 1'b0;
		link_hot_reset_rx  = 1'b0;
		link_msg_rx        = 1'b0;
		pf_func_reset_req  = 2'h0;
		vf_func_reset_req  = 6'h00;
		answer_delay       = 8'h04;
		s_reset();
		s_train();
		s_msg();
		s_func();
		s_hot();
		s_lock();
		s_cfg();
		s_reset();
		print_verdict();
	end
endmodule : test_core_reset_and_client_config
